// [shared/reload_timer_defines.svh]
`ifndef RELOAD_TIMER_DEFINES_SVH
`define RELOAD_TIMER_DEFINES_SVH

// ------------------------------------------------------------
// register offsets on the i/o space
// ------------------------------------------------------------
`define ADDR_TIMER_CONTROL  16'h0080
`define ADDR_COUNT_LOW      16'h0081
`define ADDR_COUNT_HIGH     16'h0082

// ------------------------------------------------------------
// reset values and read-back constants
// ------------------------------------------------------------
`define RESET_BYTE          8'h00
`define RESET_COUNT         16'h0000
`define UNMAPPED_READ       8'h00
`define RESERVED_READ       1'b0

// ------------------------------------------------------------
// counter values
// ------------------------------------------------------------
`define COUNT_LAST          16'h0001
`define COUNT_ZERO          16'h0000
`define COUNT_ONE           16'h0001

// ------------------------------------------------------------
// prescaler terminal counts (divider minus one)
// ------------------------------------------------------------
`define DIV_SEL_4           2'b00
`define DIV_SEL_16          2'b01
`define DIV_SEL_64          2'b10
`define DIV_SEL_256         2'b11
`define TERM_DIV_4          8'h03
`define TERM_DIV_16         8'h0f
`define TERM_DIV_64         8'h3f
`define TERM_DIV_256        8'hff
`define PRESCALE_ZERO       8'h00
`define PRESCALE_ONE        8'h01

`endif

// [shared/reload_timer_pkg.sv]
package reload_timer_pkg;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       endCountFlag;
    logic       irqEnable;
    logic       reserved;
    logic       continuousSelect;
    logic [1:0] divSelect;
    logic       reloadRestart;
    logic       timerEnable;
  } ctrl_t;

  // one i/o bus request from the processor core
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wrData;
    logic        rd;
    logic        wr;
  } io_req_t;

endpackage : reload_timer_pkg

// [rtl/reload_timer.sv]
// Overview of operation
// - five byte registers per timer instance
// - reload write-only, count read-only, shared addresses
// - end flag bit 7 cleared by control read
// - interrupt request when flag and enable set
// - single-pass: stop and clear enable at end
// - continuous: reload counter at end, keep counting
// - prescaler selects divide by 4/16/64/256
// - reload-restart bit loads counter on start
// - bit 0 enables counting
// - count reads never disturb the timer
// - low byte read latches high byte
// - low byte shows counter bits 7..0
// - end is a tick from 0001h, not a load
// - every instance owns all its state
`include "reload_timer_defines.svh"

module reload_timer (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire reload_timer_pkg::io_req_t  ioReq,
  output logic [7:0]                      ioRdData,
  output logic                            irqReq
);
  import reload_timer_pkg::*;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic [1:0] rstSync;
  logic       rst;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync <= 2'b00;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end

  assign rst = ~rstSync[1];

  // ------------------------------------------------------------
  // state, one set per instance
  // ------------------------------------------------------------
  ctrl_t       ctrl;
  logic [15:0] reload;
  logic [15:0] count;
  logic [7:0]  heldHigh;
  logic [7:0]  prescale;
  logic        tick;
  logic        endEvent;
  logic        ctrlRead;
  logic        ctrlWrite;
  logic        lowRead;
  logic        highRead;
  logic        lowWrite;
  logic        highWrite;
  logic        restart;
  ctrl_t       wrCtrl;

  function automatic logic [7:0] divTerm(input logic [1:0] sel);
    logic [7:0] t;
    t = `TERM_DIV_4;
    unique case (sel)
      `DIV_SEL_4:   t = `TERM_DIV_4;
      `DIV_SEL_16:  t = `TERM_DIV_16;
      `DIV_SEL_64:  t = `TERM_DIV_64;
      `DIV_SEL_256: t = `TERM_DIV_256;
    endcase
    return t;
  endfunction : divTerm

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // the same address reads the count and writes the reload
  assign ctrlRead  = ioReq.rd && (ioReq.addr == `ADDR_TIMER_CONTROL);
  assign ctrlWrite = ioReq.wr && (ioReq.addr == `ADDR_TIMER_CONTROL);
  assign lowRead   = ioReq.rd && (ioReq.addr == `ADDR_COUNT_LOW);
  assign highRead  = ioReq.rd && (ioReq.addr == `ADDR_COUNT_HIGH);
  assign lowWrite  = ioReq.wr && (ioReq.addr == `ADDR_COUNT_LOW);
  assign highWrite = ioReq.wr && (ioReq.addr == `ADDR_COUNT_HIGH);
  assign wrCtrl    = ctrl_t'(ioReq.wrData);
  assign restart   = ctrlWrite && wrCtrl.timerEnable
                     && wrCtrl.reloadRestart;

  // ------------------------------------------------------------
  // prescaler
  // ------------------------------------------------------------
  // held at zero while stopped so the first period is always full
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prescale <= `PRESCALE_ZERO;
    end else if (!ctrl.timerEnable || restart || tick) begin
      prescale <= `PRESCALE_ZERO;
    end else begin
      prescale <= prescale + `PRESCALE_ONE;
    end
  end

  assign tick = ctrl.timerEnable
                && (prescale == divTerm(ctrl.divSelect));

  // only a decrement from one ends the count, never a load
  assign endEvent = tick && !restart
                    && (count == `COUNT_LAST);

  // ------------------------------------------------------------
  // downcounter
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= `RESET_COUNT;
    end else if (restart) begin
      count <= reload;
    end else if (endEvent) begin
      if (ctrl.continuousSelect) begin
        count <= reload;
      end else begin
        count <= `COUNT_ZERO;
      end
    end else if (tick) begin
      // zero wraps to ffff for the longest period
      count <= count - `COUNT_ONE;
    end
  end

  // ------------------------------------------------------------
  // reload storage
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reload <= `RESET_COUNT;
    end else if (lowWrite) begin
      reload[7:0] <= ioReq.wrData;
    end else if (highWrite) begin
      reload[15:8] <= ioReq.wrData;
    end
  end

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl <= ctrl_t'(`RESET_BYTE);
    end else begin
      if (ctrlWrite) begin
        // a write in the end cycle wins, so software can restart at once
        ctrl.irqEnable        <= wrCtrl.irqEnable;
        ctrl.reserved         <= `RESERVED_READ;
        ctrl.continuousSelect <= wrCtrl.continuousSelect;
        ctrl.divSelect        <= wrCtrl.divSelect;
        ctrl.reloadRestart    <= wrCtrl.reloadRestart;
        ctrl.timerEnable      <= wrCtrl.timerEnable;
      end else if (endEvent && !ctrl.continuousSelect) begin
        ctrl.timerEnable <= 1'b0;
      end
      // flag shares this process so the register has one driver;
      // set wins over the clearing read so no end is lost
      if (endEvent) begin
        ctrl.endCountFlag <= 1'b1;
      end else if (ctrlRead) begin
        ctrl.endCountFlag <= 1'b0;
      end
    end
  end

  assign irqReq = ctrl.endCountFlag && ctrl.irqEnable;

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      heldHigh <= `RESET_BYTE;
    end else if (lowRead) begin
      heldHigh <= count[15:8];
    end
  end

  // reads only copy state; nothing here feeds the counter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ioRdData <= `RESET_BYTE;
    end else if (ctrlRead) begin
      ioRdData <= ctrl;
    end else if (lowRead) begin
      ioRdData <= count[7:0];
    end else if (highRead) begin
      ioRdData <= heldHigh;
    end else if (ioReq.rd) begin
      ioRdData <= `UNMAPPED_READ;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_flag_holds: assert property (
    @(posedge core_clk) disable iff (rst)
    ctrl.endCountFlag && !ctrlRead |=> ctrl.endCountFlag)
    else $error("end flag dropped without a control read");

  chk_flag_clears: assert property (
    @(posedge core_clk) disable iff (rst)
    ctrlRead && !endEvent |=> !ctrl.endCountFlag)
    else $error("end flag survived a control read");

  chk_irq_follows: assert property (
    @(posedge core_clk) disable iff (rst)
    endEvent && ctrl.irqEnable && !ctrlWrite |=> irqReq)
    else $error("no interrupt request after end of count");

  chk_irq_masked: assert property (
    @(posedge core_clk) disable iff (rst)
    !ctrl.irqEnable |-> !irqReq)
    else $error("interrupt request while disabled");

  chk_single_stop: assert property (
    @(posedge core_clk) disable iff (rst)
    endEvent && !ctrl.continuousSelect && !ctrlWrite
    |=> !ctrl.timerEnable && count == `COUNT_ZERO)
    else $error("single pass did not stop at end");

  chk_cont_reload: assert property (
    @(posedge core_clk) disable iff (rst)
    endEvent && ctrl.continuousSelect && !ctrlWrite
    |=> ctrl.timerEnable && count == $past(reload))
    else $error("continuous mode did not reload");

  chk_tick_spacing: assert property (
    @(posedge core_clk) disable iff (rst)
    tick && !ctrlWrite |=> !tick [*3])
    else $error("counting faster than divide by four");

  chk_div_four: assert property (
    @(posedge core_clk) disable iff (rst)
    ctrl.timerEnable && ctrl.divSelect == `DIV_SEL_4
    && prescale == `PRESCALE_ZERO && !ioReq.wr
    ##1 !ioReq.wr [*3] |-> tick)
    else $error("divide by four tick missing");

  chk_restart_load: assert property (
    @(posedge core_clk) disable iff (rst)
    restart |=> count == $past(reload)
    && (!ctrl.endCountFlag || $past(ctrl.endCountFlag)))
    else $error("restart did not load reload value");

  chk_hold_idle: assert property (
    @(posedge core_clk) disable iff (rst)
    !ctrl.timerEnable && !ctrlWrite |=> $stable(count))
    else $error("count moved while disabled");

  chk_read_quiet: assert property (
    @(posedge core_clk) disable iff (rst)
    lowRead && !tick && !ioReq.wr |=> $stable(count))
    else $error("count read disturbed the counter");

  chk_latch_high: assert property (
    @(posedge core_clk) disable iff (rst)
    lowRead |=> heldHigh == $past(count[15:8]))
    else $error("high byte not latched on low read");

  chk_low_bits: assert property (
    @(posedge core_clk) disable iff (rst)
    lowRead |=> ioRdData == $past(count[7:0]))
    else $error("low byte read shows wrong bits");

  chk_end_source: assert property (
    @(posedge core_clk) disable iff (rst)
    !ctrl.endCountFlag ##1 ctrl.endCountFlag
    |-> $past(count) == `COUNT_LAST && $past(tick))
    else $error("end flag set without a decrement from one");

  chk_reload_low: assert property (
    @(posedge core_clk) disable iff (rst)
    lowWrite |=> reload[7:0] == $past(ioReq.wrData))
    else $error("low reload byte not stored");

  chk_reload_high: assert property (
    @(posedge core_clk) disable iff (rst)
    highWrite |=> reload[15:8] == $past(ioReq.wrData))
    else $error("high reload byte not stored");

  chk_flag_ro: assert property (
    @(posedge core_clk) disable iff (rst)
    ctrlWrite && !endEvent && !ctrlRead
    |=> ctrl.endCountFlag == $past(ctrl.endCountFlag))
    else $error("end flag changed by a control write");

  chk_resume_count: assert property (
    @(posedge core_clk) disable iff (rst)
    ctrlWrite && wrCtrl.timerEnable && !wrCtrl.reloadRestart && !tick
    |=> $stable(count))
    else $error("resume without reload bit changed the count");

  chk_rsvd_zero: assert property (
    @(posedge core_clk) disable iff (rst)
    ctrlRead |=> ioRdData[5] == `RESERVED_READ)
    else $error("reserved control bit read as one");

endmodule : reload_timer

// [bench/core_model.sv]
`include "reload_timer_defines.svh"

module core_model (
  output reload_timer_pkg::io_req_t ioReq,
  input  wire logic                 core_clk,
  input  wire logic [7:0]           ioRdData
);
  timeunit 1ns;
  timeprecision 1ns;
  import reload_timer_pkg::*;

  // ------------------------------------------------------------
  // i/o cycles: strobe stands over exactly one taking edge
  // ------------------------------------------------------------
  initial ioReq = '0;

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    ioReq <= '{addr: a, wrData: d, rd: 1'b0, wr: 1'b1};
    @(posedge core_clk);
    ioReq <= '0;
  endtask : wr

  // data is registered, so it is taken one edge after the strobe edge
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge core_clk);
    ioReq <= '{addr: a, wrData: 8'h00, rd: 1'b1, wr: 1'b0};
    @(posedge core_clk);
    ioReq <= '0;
    @(posedge core_clk);
    #1 d = ioRdData;
  endtask : rd

  // every start sets the reload bit, as single-pass use demands
  task automatic start_timer(input logic [7:0] c);
    wr(`ADDR_TIMER_CONTROL, c | 8'h02);
  endtask : start_timer

  task automatic rd_count(output logic [15:0] v);
    rd(`ADDR_COUNT_LOW, v[7:0]);
    rd(`ADDR_COUNT_HIGH, v[15:8]);
  endtask : rd_count
endmodule : core_model

// [bench/tb_reload_timer.sv]
`include "reload_timer_defines.svh"

module tb_reload_timer;
  timeunit 1ns;
  timeprecision 1ns;

  logic                      core_clk = 1'b0;
  logic                      rst_n = 1'b0;
  reload_timer_pkg::io_req_t ioReq;
  logic [7:0]                ioRdData;
  logic                      irqReq;
  int                        mismatches = 0;
  int                        checked = 0;
  int                        cyc = 0;

  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  reload_timer dut (.core_clk(core_clk), .rst_n(rst_n), .ioReq(ioReq),
                    .ioRdData(ioRdData), .irqReq(irqReq));
  core_model core (.ioReq(ioReq), .core_clk(core_clk),
                   .ioRdData(ioRdData));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic cmp(input string w, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask : cmp

  task automatic rdc(input logic [15:0] a, input logic [7:0] e,
                     input string w);
    logic [7:0] d;
    core.rd(a, d);
    cmp(w, {8'h00, e}, {8'h00, d});
  endtask : rdc

  // irq is watched as a level, so no control read disturbs the flag
  task automatic wait_irq(input int bound, output int t);
    for (int i = 0; i < bound; i++) begin
      @(posedge core_clk);
      #1;
      if (irqReq === 1'b1) begin
        t = cyc;
        return;
      end
    end
    mismatches++;
    $display("unexpected timeout waiting for irqReq");
    end_of_test();
  endtask : wait_irq

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int t0;
    int t1;
    int dv;
    logic [15:0] v;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdc(`ADDR_TIMER_CONTROL, 8'h00, "ctrl reset");
    rdc(`ADDR_COUNT_LOW, 8'h00, "low reset");
    rdc(`ADDR_COUNT_HIGH, 8'h00, "high reset");
    rdc(16'h0090, 8'h00, "unmapped read");
    core.wr(`ADDR_TIMER_CONTROL, 8'hac);
    rdc(`ADDR_TIMER_CONTROL, 8'h0c, "ctrl reserved");
    // single pass at every prescaler; t0 is one edge before the write
    // is driven, so strobe, restart edge and offset add three cycles
    for (int s = 0; s < 4; s++) begin
      dv = 4 << (2 * s);
      core.wr(`ADDR_COUNT_LOW, 8'h02);
      core.wr(`ADDR_COUNT_HIGH, 8'h00);
      t0 = cyc;
      core.start_timer(8'h41 | 8'(s << 2));
      wait_irq(2048, t1);
      cmp("single period", 16'(2 * dv + 3), 16'(t1 - t0));
      rdc(`ADDR_TIMER_CONTROL, 8'hc2 | 8'(s << 2), "ctrl end");
      cmp("irq after read", 16'h0000, {15'h0000, irqReq});
      rdc(`ADDR_TIMER_CONTROL, 8'h42 | 8'(s << 2), "ctrl clear");
      rdc(`ADDR_COUNT_LOW, 8'h00, "end count");
    end
    core.wr(`ADDR_COUNT_LOW, 8'h01);
    core.start_timer(8'h01);
    repeat (12) @(posedge core_clk);
    cmp("irq masked", 16'h0000, {15'h0000, irqReq});
    rdc(`ADDR_TIMER_CONTROL, 8'h82, "ctrl masked");
    // continuous: period stays exact although count is read meanwhile
    core.wr(`ADDR_COUNT_LOW, 8'h03);
    core.start_timer(8'h51);
    wait_irq(64, t0);
    rdc(`ADDR_TIMER_CONTROL, 8'hd3, "ctrl cont");
    core.rd_count(v);
    cmp("cont count", 16'h0002, v);
    wait_irq(64, t1);
    cmp("cont period", 16'd12, 16'(t1 - t0));
    rdc(`ADDR_TIMER_CONTROL, 8'hd3, "ctrl cont again");
    core.wr(`ADDR_TIMER_CONTROL, 8'h00);
    // freeze count at 0100h, then reload 0201h and read stale high
    core.wr(`ADDR_COUNT_LOW, 8'h00);
    core.wr(`ADDR_COUNT_HIGH, 8'h01);
    core.start_timer(8'h01);
    core.wr(`ADDR_TIMER_CONTROL, 8'h00);
    repeat (20) @(posedge core_clk);
    rdc(`ADDR_COUNT_LOW, 8'h00, "frozen low");
    core.wr(`ADDR_COUNT_LOW, 8'h01);
    core.wr(`ADDR_COUNT_HIGH, 8'h02);
    // resume without the reload bit keeps the frozen count
    core.wr(`ADDR_TIMER_CONTROL, 8'h11);
    core.wr(`ADDR_TIMER_CONTROL, 8'h00);
    rdc(`ADDR_COUNT_LOW, 8'h00, "resume low");
    core.start_timer(8'h01);
    core.wr(`ADDR_TIMER_CONTROL, 8'h00);
    rdc(`ADDR_COUNT_HIGH, 8'h01, "held high");
    rdc(`ADDR_COUNT_LOW, 8'h01, "new low");
    rdc(`ADDR_COUNT_HIGH, 8'h02, "new high");
    // a load of zero is not an end of count
    core.wr(`ADDR_COUNT_LOW, 8'h00);
    core.wr(`ADDR_COUNT_HIGH, 8'h00);
    core.start_timer(8'h41);
    repeat (2) @(posedge core_clk);
    core.wr(`ADDR_TIMER_CONTROL, 8'h40);
    cmp("irq zero load", 16'h0000, {15'h0000, irqReq});
    rdc(`ADDR_TIMER_CONTROL, 8'h40, "ctrl zero load");
    core.rd_count(v);
    cmp("zero wrap", 16'hffff, v);
    end_of_test();
  end
endmodule : tb_reload_timer
